//--- src/tsc_pkg.sv
// Purpose: shared constants and types for the telemetry schedule and bias select link
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes: channel index 0 vin, 1 temp, 2 iout, 3 vout
package tsc_pkg;
  // command codes and block byte counts
  localparam logic [7:0] CMD_BIAS = 8'hB5;
  localparam logic [7:0] CMD_TLM = 8'hD0;
  localparam logic [3:0] BIAS_BYTES = 4'h1;
  localparam logic [3:0] TLM_BYTES = 4'h6;
  localparam logic [3:0] NO_BYTES = 4'h0;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TXN_MAX_NS = 1000000;
  localparam int ACTION_MAX_NS = 1000000;
  localparam int TXN_MAX_CYCLES = TXN_MAX_NS / CLK_PERIOD_NS;
  localparam int ACTION_MAX_CYCLES = ACTION_MAX_NS / CLK_PERIOD_NS;

  // bias regulator select register
  localparam int BIAS_CODE_LSB = 4;
  localparam logic [3:0] VCODE_MIN = 4'h3;
  localparam logic [3:0] VCODE_MAX = 4'hA;
  localparam logic [3:0] VCODE_RESET = 4'h9;
  localparam logic [3:0] BIAS_RSVD_VALUE = 4'h0;

  // telemetry schedule register
  localparam int NCH = 4;
  localparam int CH_VIN = 0;
  localparam int CH_TEMP = 1;
  localparam int CH_IOUT = 2;
  localparam int CH_VOUT = 3;
  localparam int PRI_LSB0 = 30;
  localparam int AVG_LSB0 = 24;
  localparam int CH_STRIDE = 8;
  localparam logic [47:0] TLM_RESET = 48'h0003_0000_0000;
  localparam logic [47:0] TLM_RO_MASK = 48'hFF00_0000_0000;
  localparam logic [1:0] PRI_A = 2'h0;
  localparam logic [1:0] PRI_B = 2'h1;
  localparam logic [1:0] PRI_C = 2'h2;
  localparam logic [1:0] PRI_OFF = 2'h3;
  localparam logic [2:0] AVG_MAX = 3'h5;
  localparam logic [15:0] READ_DISABLED = 16'h0000;

  // host registers, byte addresses on the avalon slave
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_WLO = 5'h04;
  localparam logic [4:0] REG_WHI = 5'h08;
  localparam logic [4:0] REG_RLO = 5'h0C;
  localparam logic [4:0] REG_RHI = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_EXT_BIAS = 2;
  localparam int CTRL_CODE_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_TIMEOUT = 3;
  localparam int STAT_REFUSED = 4;

  typedef enum logic [1:0] {SCH_PICK = 2'b01, SCH_WAIT = 2'b10} tsc_sched_t;
  typedef enum logic [1:0] {HST_IDLE = 2'b01, HST_WAIT = 2'b10} tsc_host_t;
endpackage

//--- src/tsc_link_if.sv
// Purpose: block transaction link between host controller and device
// Assumes: both ends on i_clock
// Notes: req held by host until one-cycle ack
`timescale 1ns/1ps
interface tsc_link_if;
  logic req;
  logic rnw;
  logic [7:0] code;
  logic [3:0] count;
  logic [47:0] wdata;
  logic ack;
  logic err;
  logic [3:0] rcount;
  logic [47:0] rdata;
  modport host (output req, rnw, code, count, wdata, input ack, err, rcount, rdata);
  modport dev (input req, rnw, code, count, wdata, output ack, err, rcount, rdata);
endinterface

//--- src/tsc_avg.sv
// Purpose: rolling average of 2^n samples for one telemetry channel
// Assumes: n already limited to 0..5
// Notes: running-sum form, reseeded when n changes
`timescale 1ns/1ps
module tsc_avg (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [15:0] i_sample,
  input wire logic [2:0] i_n,
  output logic [15:0] o_avg
);
  logic [20:0] acc_q;
  logic [2:0] n_q;
  logic primed_q;

  // reseed avoids a long settle after a new window length
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      acc_q <= 21'h000000;
      n_q <= 3'h0;
      primed_q <= 1'b0;
    end
    else if (i_valid)
    begin
      if (!primed_q || (i_n != n_q))
        acc_q <= 21'(i_sample) << i_n;
      else
        acc_q <= acc_q - (acc_q >> n_q) + 21'(i_sample);
      n_q <= i_n;
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avg <= 16'h0000;
    else
      o_avg <= 16'(acc_q >> n_q);
  end
endmodule

//--- src/tsc_device.sv
// Purpose: device end: bias select and telemetry schedule registers, adc scheduler
// Assumes: adc handshake and link on i_clock
// Notes: settings apply the cycle after the write acknowledge
// Functional notes
// [RULE1] bias write is block of one byte
// [RULE2] bias read returns block of one byte
// [RULE3] finish transaction and apply within 1 ms
// [RULE4] code bits 7:4, 3h..Ah valid only
// [RULE5] bias bits 3:0 read zero, host writes zero
// [RULE6] host avoids 3h without external bias
// [RULE7] telemetry config is six-byte block
// [RULE8] one shared adc, one measurement at a time
// [RULE9] all priority A channels each pass first
// [RULE10] one rotating B after each A pass
// [RULE11] one rotating C after each B pass
// [RULE12] priority 00 A, 01 B, 10 C, 11 off
// [RULE13] average 2^N samples, N 0..5
// [RULE14] disabled channel reads back 0000h
// [RULE15] temperature is never disabled
// [RULE16] fields: vin 31:30/26:24, temp 23:22/18:16, iout, vout
// [RULE17] new settings take effect on the fly
`timescale 1ns/1ps
module tsc_device (
  input wire logic i_clock,
  input wire logic i_rstn,
  tsc_link_if.dev link,
  output logic o_adc_start,
  output logic [1:0] o_adc_chan,
  input wire logic i_adc_done,
  input wire logic [15:0] i_adc_data,
  output logic [3:0] o_regulator_code,
  output logic [63:0] o_readback
);
  logic [3:0] regulator_voltage_code_q;
  logic [47:0] tlm_q;
  logic take;
  logic bias_ok;
  logic tlm_ok;
  logic code_valid;
  logic [3:0] wr_code;

  assign take = link.req && !link.ack;
  assign wr_code = link.wdata[tsc_pkg::BIAS_CODE_LSB +: 4];
  assign code_valid = (wr_code >= tsc_pkg::VCODE_MIN) && (wr_code <= tsc_pkg::VCODE_MAX); // see [RULE4]
  assign bias_ok = (link.code == tsc_pkg::CMD_BIAS) && (link.count == tsc_pkg::BIAS_BYTES); // see [RULE1] [RULE2]
  assign tlm_ok = (link.code == tsc_pkg::CMD_TLM) && (link.count == tsc_pkg::TLM_BYTES); // see [RULE7]

  // answer one cycle after the request: far inside the transaction limit
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      link.ack <= 1'b0;
      link.err <= 1'b0;
      link.rcount <= tsc_pkg::NO_BYTES;
      link.rdata <= 48'h0000_0000_0000;
    end
    else
    begin
      link.ack <= take; // see [RULE3]
      if (take)
      begin
        link.err <= !(bias_ok || tlm_ok) || (bias_ok && !link.rnw && !code_valid);
        link.rcount <= tsc_pkg::NO_BYTES;
        link.rdata <= 48'h0000_0000_0000;
        if (bias_ok && link.rnw)
        begin
          link.rcount <= tsc_pkg::BIAS_BYTES; // see [RULE2]
          link.rdata <= {40'h00_0000_0000, regulator_voltage_code_q, tsc_pkg::BIAS_RSVD_VALUE}; // see [RULE5]
        end
        else if (tlm_ok && link.rnw)
        begin
          link.rcount <= tsc_pkg::TLM_BYTES; // see [RULE7]
          link.rdata <= tlm_q;
        end
      end
    end
  end

  // invalid codes leave the regulator where it was
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      regulator_voltage_code_q <= tsc_pkg::VCODE_RESET;
    else if (take && bias_ok && !link.rnw && code_valid)
      regulator_voltage_code_q <= wr_code; // see [RULE4] [RULE17]
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      tlm_q <= tsc_pkg::TLM_RESET;
    else if (take && tlm_ok && !link.rnw)
      tlm_q <= (link.wdata & ~tsc_pkg::TLM_RO_MASK) | (tlm_q & tsc_pkg::TLM_RO_MASK); // see [RULE17]
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_regulator_code <= tsc_pkg::VCODE_RESET;
    else
      o_regulator_code <= regulator_voltage_code_q; // see [RULE3]
  end

  // effective priority and averaging per channel
  logic [1:0] pri [tsc_pkg::NCH];
  logic [2:0] avg_n [tsc_pkg::NCH];
  logic [3:0] a_m;
  logic [3:0] b_m;
  logic [3:0] c_m;

  always_comb
  begin
    for (int i = 0; i < tsc_pkg::NCH; i++)
    begin
      pri[i] = tlm_q[tsc_pkg::PRI_LSB0 - tsc_pkg::CH_STRIDE * i +: 2]; // see [RULE16]
      if ((i == tsc_pkg::CH_TEMP) && (pri[i] == tsc_pkg::PRI_OFF))
        pri[i] = tsc_pkg::PRI_C; // see [RULE15]
      avg_n[i] = tlm_q[tsc_pkg::AVG_LSB0 - tsc_pkg::CH_STRIDE * i +: 3]; // see [RULE16]
      if (avg_n[i] > tsc_pkg::AVG_MAX)
        avg_n[i] = tsc_pkg::AVG_MAX; // see [RULE13]
      a_m[i] = (pri[i] == tsc_pkg::PRI_A); // see [RULE12]
      b_m[i] = (pri[i] == tsc_pkg::PRI_B);
      c_m[i] = (pri[i] == tsc_pkg::PRI_C);
    end
  end

  // first set bit of mask at or above start; bit 2 of result is found
  function automatic logic [2:0] find_from(input logic [3:0] mask, input logic [2:0] start);
    logic [2:0] res;
    res = 3'h0;
    for (int i = tsc_pkg::NCH - 1; i >= 0; i--)
      if (mask[i] && (3'(i) >= start))
        res = {1'b1, 2'(i)};
    return res;
  endfunction

  tsc_pkg::tsc_sched_t sch_q;
  logic [2:0] a_pos_q;
  logic [2:0] b_pos_q;
  logic [2:0] c_pos_q;
  logic [2:0] fa;
  logic [2:0] fb;
  logic [2:0] fc;
  logic [2:0] fc0;

  assign fa = find_from(a_m, a_pos_q);
  assign fb = find_from(b_m, b_pos_q);
  assign fc = find_from(c_m, c_pos_q);
  assign fc0 = find_from(c_m, 3'h0);

  // a pass over A, then one slot of the B rotation; the B rotation ends in one C
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      sch_q <= tsc_pkg::SCH_PICK;
      a_pos_q <= 3'h0;
      b_pos_q <= 3'h0;
      c_pos_q <= 3'h0;
      o_adc_start <= 1'b0;
      o_adc_chan <= 2'h0;
    end
    else
    begin
      o_adc_start <= 1'b0;
      unique case (sch_q)
        tsc_pkg::SCH_PICK:
        begin
          if (fa[2])
          begin
            o_adc_chan <= fa[1:0]; // see [RULE9]
            o_adc_start <= 1'b1;
            a_pos_q <= {1'b0, fa[1:0]} + 3'h1;
            sch_q <= tsc_pkg::SCH_WAIT;
          end
          else if (fb[2])
          begin
            o_adc_chan <= fb[1:0]; // see [RULE10]
            o_adc_start <= 1'b1;
            b_pos_q <= {1'b0, fb[1:0]} + 3'h1;
            a_pos_q <= 3'h0;
            sch_q <= tsc_pkg::SCH_WAIT;
          end
          else
          begin
            a_pos_q <= 3'h0;
            b_pos_q <= 3'h0;
            if (fc[2] || fc0[2])
            begin
              o_adc_chan <= fc[2] ? fc[1:0] : fc0[1:0]; // see [RULE11]
              o_adc_start <= 1'b1;
              c_pos_q <= {1'b0, (fc[2] ? fc[1:0] : fc0[1:0])} + 3'h1;
              sch_q <= tsc_pkg::SCH_WAIT;
            end
          end
        end
        tsc_pkg::SCH_WAIT:
        begin
          if (i_adc_done)
            sch_q <= tsc_pkg::SCH_PICK; // see [RULE8]
        end
      endcase
    end
  end

  // only the channel in conversion takes the sample
  logic [15:0] avg_out [tsc_pkg::NCH];

  for (genvar g = 0; g < tsc_pkg::NCH; g++)
  begin : g_ch
    tsc_avg u_avg (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_valid(i_adc_done && (sch_q == tsc_pkg::SCH_WAIT) && (o_adc_chan == 2'(g))),
      .i_sample(i_adc_data),
      .i_n(avg_n[g]), // see [RULE13] [RULE17]
      .o_avg(avg_out[g])
    );

    always_ff @(posedge i_clock)
    begin
      if (!i_rstn)
        o_readback[16 * g +: 16] <= tsc_pkg::READ_DISABLED;
      else if (pri[g] == tsc_pkg::PRI_OFF)
        o_readback[16 * g +: 16] <= tsc_pkg::READ_DISABLED; // see [RULE14]
      else
        o_readback[16 * g +: 16] <= avg_out[g];
    end
  end
endmodule

//--- src/tsc_host.sv
// Purpose: host end: takes orders over avalon-mm and runs block transactions on the link
// Assumes: one avalon access in flight
// Notes: waitrequest low on the second cycle of every access
`timescale 1ns/1ps
module tsc_host #(
  parameter int TXN_TIMEOUT = tsc_pkg::TXN_MAX_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  tsc_link_if.host link
);
  tsc_pkg::tsc_host_t st_q;
  logic [47:0] wdata_q;
  logic [47:0] rdata_q;
  logic done_q;
  logic err_q;
  logic tmo_q;
  logic refused_q;
  logic [31:0] wait_q;
  logic acc;
  logic go;
  logic [7:0] go_code;
  logic go_rd;
  logic low_bias;

  assign acc = (i_avs_read || i_avs_write) && o_avs_waitrequest == 1'b0;
  assign go = acc && i_avs_write && (i_avs_address == tsc_pkg::REG_CTRL)
              && i_avs_writedata[tsc_pkg::CTRL_GO] && (st_q == tsc_pkg::HST_IDLE);
  assign go_code = i_avs_writedata[tsc_pkg::CTRL_CODE_LSB +: 8];
  assign go_rd = i_avs_writedata[tsc_pkg::CTRL_RD];
  assign low_bias = (go_code == tsc_pkg::CMD_BIAS) && !go_rd
                    && (wdata_q[tsc_pkg::BIAS_CODE_LSB +: 4] == tsc_pkg::VCODE_MIN)
                    && !i_avs_writedata[tsc_pkg::CTRL_EXT_BIAS]; // see [RULE6]

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avs_waitrequest <= 1'b1;
    else if (o_avs_waitrequest)
      o_avs_waitrequest <= !(i_avs_read || i_avs_write);
    else
      o_avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avs_readdata <= 32'h0000_0000;
    else if (o_avs_waitrequest && i_avs_read)
    begin
      unique case (i_avs_address)
        tsc_pkg::REG_WLO: o_avs_readdata <= wdata_q[31:0];
        tsc_pkg::REG_WHI: o_avs_readdata <= {16'h0000, wdata_q[47:32]};
        tsc_pkg::REG_RLO: o_avs_readdata <= rdata_q[31:0];
        tsc_pkg::REG_RHI: o_avs_readdata <= {16'h0000, rdata_q[47:32]};
        tsc_pkg::REG_STAT: o_avs_readdata <= {27'h000_0000, refused_q, tmo_q, err_q, done_q,
                                              st_q == tsc_pkg::HST_WAIT};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      wdata_q <= 48'h0000_0000_0000;
    else if (acc && i_avs_write && (i_avs_address == tsc_pkg::REG_WLO))
      wdata_q[31:0] <= i_avs_writedata;
    else if (acc && i_avs_write && (i_avs_address == tsc_pkg::REG_WHI))
      wdata_q[47:32] <= i_avs_writedata[15:0];
  end

  // count fixed by command code, so a block never carries a wrong length
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      st_q <= tsc_pkg::HST_IDLE;
      link.req <= 1'b0;
      link.rnw <= 1'b0;
      link.code <= 8'h00;
      link.count <= tsc_pkg::NO_BYTES;
      link.wdata <= 48'h0000_0000_0000;
      rdata_q <= 48'h0000_0000_0000;
      done_q <= 1'b0;
      err_q <= 1'b0;
      tmo_q <= 1'b0;
      refused_q <= 1'b0;
      wait_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (st_q)
        tsc_pkg::HST_IDLE:
        begin
          if (go)
          begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            tmo_q <= 1'b0;
            refused_q <= low_bias;
            if (!low_bias)
            begin
              link.req <= 1'b1;
              link.rnw <= go_rd;
              link.code <= go_code;
              link.count <= (go_code == tsc_pkg::CMD_BIAS) ? tsc_pkg::BIAS_BYTES : // see [RULE1] [RULE2]
                            (go_code == tsc_pkg::CMD_TLM) ? tsc_pkg::TLM_BYTES : tsc_pkg::NO_BYTES; // see [RULE7]
              link.wdata <= (go_code == tsc_pkg::CMD_BIAS) ? {40'h00_0000_0000, wdata_q[7:4],
                            tsc_pkg::BIAS_RSVD_VALUE} : wdata_q; // see [RULE5]
              wait_q <= 32'h0000_0000;
              st_q <= tsc_pkg::HST_WAIT;
            end
          end
        end
        tsc_pkg::HST_WAIT:
        begin
          wait_q <= wait_q + 32'h0000_0001;
          if (link.ack)
          begin
            link.req <= 1'b0;
            done_q <= 1'b1;
            err_q <= link.err;
            if (link.rnw)
              rdata_q <= link.rdata;
            st_q <= tsc_pkg::HST_IDLE;
          end
          else if (wait_q >= 32'(TXN_TIMEOUT - 1))
          begin
            link.req <= 1'b0; // see [RULE3]
            tmo_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= tsc_pkg::HST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

//--- tb/tsc_checker.sv
// Purpose: watches the block transaction link between host and device ends
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the link signals
`timescale 1ns/1ps
module tsc_checker (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic req,
  input wire logic rnw,
  input wire logic [7:0] code,
  input wire logic [3:0] count,
  input wire logic [47:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [3:0] rcount,
  input wire logic [47:0] rdata
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  wire take = req && !ack;
  wire bias = code == tsc_pkg::CMD_BIAS;
  wire tlm = code == tsc_pkg::CMD_TLM;
  property p_ack_lat;
    take |=> ack ##1 !ack;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not a one-cycle pulse after request");
  property p_req_hold;
    take |=> req && $stable(code) && $stable(rnw) && $stable(wdata) && $stable(count);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop;
    ack |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_bias_cnt;
    req && bias |-> count == tsc_pkg::BIAS_BYTES;
  endproperty
  a_bias_cnt: assert property (p_bias_cnt) else $error("bias block count wrong");
  property p_tlm_cnt;
    req && tlm |-> count == tsc_pkg::TLM_BYTES;
  endproperty
  a_tlm_cnt: assert property (p_tlm_cnt) else $error("telemetry block count wrong");
  property p_bias_rd;
    ack && !err && rnw && bias |-> rcount == tsc_pkg::BIAS_BYTES && rdata[47:8] == 40'h0 && rdata[3:0] == 4'h0;
  endproperty
  a_bias_rd: assert property (p_bias_rd) else $error("bias read not one byte with zero low nibble");
  property p_tlm_rd;
    ack && !err && rnw && tlm |-> rcount == tsc_pkg::TLM_BYTES && rdata[47:40] == 8'h00;
  endproperty
  a_tlm_rd: assert property (p_tlm_rd) else $error("telemetry read not six bytes");
  property p_bias_rng;
    take && !rnw && bias && count == tsc_pkg::BIAS_BYTES
      && (wdata[7:4] < tsc_pkg::VCODE_MIN || wdata[7:4] > tsc_pkg::VCODE_MAX) |=> ack && err;
  endproperty
  a_bias_rng: assert property (p_bias_rng) else $error("invalid bias code accepted");
  property p_bad_cmd;
    take && !bias && !tlm |=> err;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command accepted");
  c_bias_wr: cover property (ack && !err && !rnw && bias);
  c_tlm_rd: cover property (ack && !err && rnw && tlm);
  c_err: cover property (ack && err);
endmodule

//--- tb/tb_top.sv
// Purpose: drives the host over avalon-mm, device faces it over the link
// Assumes: one 125 MHz clock, adc modelled in the bench
// Notes: adc answers 4 cycles after each start
`timescale 1ns/1ps
module tb_top;
  logic i_clock;
  logic i_rstn;
  logic [4:0] adr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wd_s;
  logic [31:0] rdata_s;
  logic wait_s;
  logic adc_start;
  logic [1:0] adc_chan;
  logic adc_done;
  logic [15:0] adc_data;
  logic [3:0] regulator_code;
  logic [63:0] readback;
  logic [1:0] seq[$];
  int busy_cnt;
  int fails;
  int check_count;
  tsc_link_if u_tsc_link_if ();
  tsc_host #(.TXN_TIMEOUT(20)) u_tsc_host (.i_clock(i_clock), .i_rstn(i_rstn), .i_avs_address(adr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd_s), .o_avs_readdata(rdata_s),
    .o_avs_waitrequest(wait_s), .link(u_tsc_link_if));
  tsc_device u_tsc_device (.i_clock(i_clock), .i_rstn(i_rstn), .link(u_tsc_link_if),
    .o_adc_start(adc_start), .o_adc_chan(adc_chan), .i_adc_done(adc_done), .i_adc_data(adc_data),
    .o_regulator_code(regulator_code), .o_readback(readback));
  tsc_checker u_tsc_checker (.i_clock(i_clock), .i_rstn(i_rstn), .req(u_tsc_link_if.req),
    .rnw(u_tsc_link_if.rnw), .code(u_tsc_link_if.code), .count(u_tsc_link_if.count),
    .wdata(u_tsc_link_if.wdata), .ack(u_tsc_link_if.ack), .err(u_tsc_link_if.err),
    .rcount(u_tsc_link_if.rcount), .rdata(u_tsc_link_if.rdata));
  function automatic logic [15:0] samp(input logic [1:0] c);
    return {6'h00, c, 8'h3C};
  endfunction
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // adc data line shows a toggling pattern outside the done cycle
  always @(posedge i_clock)
  begin
    if (adc_start)
      cmp(busy_cnt == 0, 1'b1);
    if (adc_start)
      seq.push_back(adc_chan);
    busy_cnt <= adc_start ? 3 : (busy_cnt != 0 ? busy_cnt - 1 : 0);
    adc_done <= busy_cnt == 1 && !adc_start;
    adc_data <= (busy_cnt == 1) ? samp(adc_chan) : ~adc_data;
  end
  task automatic avs(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    adr <= a;
    wr_s <= w;
    rd_s <= !w;
    wd_s <= d;
    @(posedge i_clock);
    // only the watchdog ends a stalled access
    while (wait_s !== 1'b0)
      @(posedge i_clock);
    q = rdata_s;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic txn(input logic [7:0] cmd, input logic r, input logic ext, input logic [47:0] wd,
                     output logic [31:0] st, output logic [47:0] rv);
    logic [31:0] lo;
    logic [31:0] hi;
    avs(tsc_pkg::REG_WLO, 1'b1, wd[31:0], lo);
    avs(tsc_pkg::REG_WHI, 1'b1, {16'h0000, wd[47:32]}, lo);
    avs(tsc_pkg::REG_CTRL, 1'b1, {16'h0000, cmd, 5'h00, ext, r, 1'b1}, lo);
    st = 32'h0000_0000;
    while (st[tsc_pkg::STAT_DONE] !== 1'b1 && st[tsc_pkg::STAT_REFUSED] !== 1'b1)
      avs(tsc_pkg::REG_STAT, 1'b0, 32'h0000_0000, st);
    avs(tsc_pkg::REG_RLO, 1'b0, 32'h0000_0000, lo);
    avs(tsc_pkg::REG_RHI, 1'b0, 32'h0000_0000, hi);
    rv = {hi[15:0], lo};
    repeat (2) @(posedge i_clock);
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  initial
  begin
    repeat (30000) @(posedge i_clock);
    fails++;
    summarize();
  end
  initial
  begin
    logic [31:0] st;
    logic [47:0] rv;
    logic [3:0] ec;
    int i;
    int j;
    i_rstn = 1'b0;
    adr = 5'h00;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wd_s = 32'h0000_0000;
    adc_done = 1'b0;
    adc_data = 16'h0000;
    busy_cnt = 0;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'b1;
    txn(tsc_pkg::CMD_TLM, 1'b1, 1'b0, 48'h0, st, rv);
    cmp(rv, tsc_pkg::TLM_RESET);
    txn(tsc_pkg::CMD_BIAS, 1'b1, 1'b0, 48'h0, st, rv);
    cmp(rv, 48'h90);
    ec = 4'h9;
    for (i = 0; i < 16; i++)
    begin
      txn(tsc_pkg::CMD_BIAS, 1'b0, 1'b1, {40'h0, i[3:0], 4'h0}, st, rv);
      if (i >= 3 && i <= 10)
        ec = i[3:0];
      cmp(st[tsc_pkg::STAT_ERR], i < 3 || i > 10);
      cmp(regulator_code, ec);
    end
    txn(tsc_pkg::CMD_BIAS, 1'b1, 1'b0, 48'h0, st, rv);
    cmp(rv, 48'hA0);
    txn(tsc_pkg::CMD_BIAS, 1'b0, 1'b0, 48'h30, st, rv);
    cmp(st[tsc_pkg::STAT_REFUSED], 1'b1);
    cmp(regulator_code, 4'hA);
    txn(8'h00, 1'b1, 1'b0, 48'h0, st, rv);
    cmp(st[tsc_pkg::STAT_ERR], 1'b1);
    // vin off, temp 11b (kept as C), iout B, vout A with a 4-sample window
    txn(tsc_pkg::CMD_TLM, 1'b0, 1'b0, 48'hFF03_C0C0_4002, st, rv);
    txn(tsc_pkg::CMD_TLM, 1'b1, 1'b0, 48'h0, st, rv);
    cmp(rv, 48'h0003_C0C0_4002);
    repeat (100) @(posedge i_clock);
    seq.delete();
    i = 0;
    while (seq.size() < 13 && i < 2000)
    begin
      @(posedge i_clock);
      i++;
    end
    j = 0;
    while (j < 4 && seq[j] !== 2'd1)
      j++;
    for (i = 0; i < 8; i++)
      cmp(seq[j + 1 + i], (i % 2 == 0) ? 2'd3 : ((i % 4 == 1) ? 2'd2 : 2'd1));
    cmp(readback[15:0], tsc_pkg::READ_DISABLED);
    cmp(readback[31:16], samp(2'd1));
    cmp(readback[63:48], samp(2'd3));
    avs(5'h1C, 1'b0, 32'h0000_0000, st);
    cmp(st, 32'h0000_0000);
    summarize();
  end
endmodule
